// ### hbat_consts.svh
// named constants for the host bus access block
// assumes inclusion by bare name from the package and the design file
`ifndef HBAT_CONSTS_SVH
`define HBAT_CONSTS_SVH
`define HBAT_CLK_MHZ 50
`define HBAT_RESET_MS 1
`define HBAT_OSC_MS 3
`define HBAT_WAIT_TS 4
`define HBAT_RDATA_TS 1
`define HBAT_PSAVE_INDEX 8'h08
`define HBAT_PSAVE_BIT 0
`define HBAT_SYSSET_CMD 8'h40
`define HBAT_ADDR_W 16
`define HBAT_DATA_W 8
`define HBAT_REG_N 16
`define HBAT_IDX_W 4
`define HBAT_SYNC_IDLE 3'h7
`define HBAT_LINE_LAST 8'hFF
`endif

// ### hbat_host_model.sv
// host model: 8-bit bus master using the wait handshake
// assumes the bench resolves the wait pin and the shared data bus
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// host side of the bus
// ------------------------------
module hbat_host_model (
    input wire logic i_ref_clk,
    input wire logic i_wait,
    input wire logic [7:0] i_bus,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [15:0] o_addr,
    output logic [7:0] o_data
);
    // idle levels; address and data carry junk while no access runs
    initial
    begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 16'h5A5A;
        o_data = 8'hC3;
    end
    // one access, held whole until the stall is over
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output int lows);
        int n;
        lows = 0;
        n = 0;
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        o_addr <= a;
        o_data <= d;
        o_rd_n <= wr;
        o_wr_n <= !wr;
        // bounded: a stuck stall ends the access anyway
        do
        begin
            @(posedge i_ref_clk);
            n++;
            if (i_wait === 1'b0) lows++;
        end
        while (!(lows > 0 && i_wait === 1'b1) && n < 20);
        // read data taken at the edge where wait is seen high again
        q = i_bus;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_addr <= ~a;
        o_data <= ~d;
        repeat (6) @(posedge i_ref_clk);
    endtask
endmodule // hbat_host_model
`default_nettype wire

// ### hbat_host_port.sv
// host bus access port: synchronised strobes, wait handshake, power save exit
// assumes host inputs synchronous to i_ref_clk; pads resolve enables to wires
`timescale 1ns/10ps
`default_nettype none
`include "hbat_consts.svh"

// What this block does
// - direct mode: write of bit 0 at index 08h exits power save
// - indirect mode: system initialisation command exits power save
// - during reset host accesses have no effect
// - during reset panel data, line pulse and frame polarity halted
// - wait driven low shortly after a strobe falls
// - wait low no longer than four clock periods per access
// - read data valid within one period after wait rises
// - wait released to high impedance after strobe rises
// - without wait, read data valid within four periods of strobe
module hbat_host_port
    import hbat_pkg::*;
#(
    parameter int WAIT_CYCLES = `HBAT_WAIT_TS,
    parameter bit DIRECT_MODE = 1'b1
)(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [`HBAT_ADDR_W-1:0] i_addr,
    input wire logic [`HBAT_DATA_W-1:0] i_data,
    input wire logic i_pixel_run,
    input wire logic [3:0] i_pixel,
    output logic [`HBAT_DATA_W-1:0] o_data,
    output logic o_data_oe_n,
    output logic o_wait_n,
    output logic o_wait_oe_n,
    output logic o_power_save,
    output logic [3:0] o_panel_pixel_out,
    output logic o_panel_line_pulse,
    output logic o_panel_frame_polarity
);
    localparam int WAIT_W = $clog2(WAIT_CYCLES + 1);

    //------------------------------------------------------------
    // synchronisers
    //------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    hbat_req_s req;
    hbat_state_e state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [`HBAT_DATA_W-1:0] regs [`HBAT_REG_N];
    logic [7:0] line_cnt;

    // two flops per strobe; third stage only for edge detect
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1 <= `HBAT_SYNC_IDLE;
            sync2 <= `HBAT_SYNC_IDLE;
            sync3 <= `HBAT_SYNC_IDLE;
        end
        else
        begin
            sync1 <= {i_cs_n, i_rd_n, i_wr_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic strobe_on;
    logic strobe_fell;
    assign strobe_on = !sync2[2] && (!sync2[1] || !sync2[0]);
    assign strobe_fell = strobe_on && !(!sync3[2] && (!sync3[1] || !sync3[0]));

    //------------------------------------------------------------
    // access sequencer
    //------------------------------------------------------------
    // state ignores strobes while reset holds, so nothing is taken
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= HBAT_IDLE;
            wait_cnt <= '0;
            req <= '0;
        end
        else
        begin
            case (state)
                HBAT_IDLE:
                    if (strobe_fell)
                    begin
                        req <= '{addr: i_addr, data: i_data, write: !sync2[0]};
                        wait_cnt <= '0;
                        state <= HBAT_STALL;
                    end
                HBAT_STALL:
                    // counter bounds the stall to the figure
                    if (wait_cnt == WAIT_W'(WAIT_CYCLES - 2))
                        state <= HBAT_DONE;
                    else
                        wait_cnt <= wait_cnt + 1'b1;
                HBAT_DONE:
                    state <= HBAT_HOLD;
                HBAT_HOLD:
                    if (!strobe_on)
                        state <= HBAT_IDLE;
                default:
                    state <= HBAT_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // register store and power save
    //------------------------------------------------------------
    logic take_write;
    assign take_write = (state == HBAT_DONE) && req.write;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < `HBAT_REG_N; k++)
                regs[k] <= '0;
            o_power_save <= 1'b1;
        end
        else if (take_write)
        begin
            regs[req.addr[`HBAT_IDX_W-1:0]] <= req.data;
            if (DIRECT_MODE && req.addr[7:0] == `HBAT_PSAVE_INDEX
                && req.data[`HBAT_PSAVE_BIT])
                o_power_save <= 1'b0;
            if (!DIRECT_MODE && req.addr[0] && req.data == `HBAT_SYSSET_CMD)
                o_power_save <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // host pin drivers
    //------------------------------------------------------------
    // data is loaded from the first stall clock, three clocks before wait rises, well inside the window
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_wait_n <= 1'b1;
            o_wait_oe_n <= 1'b1;
            o_data <= '0;
            o_data_oe_n <= 1'b1;
        end
        else
        begin
            o_wait_n <= !(state == HBAT_IDLE ? strobe_fell : state == HBAT_STALL);
            o_wait_oe_n <= !((state == HBAT_IDLE && strobe_fell) ||
                             state == HBAT_STALL || state == HBAT_DONE ||
                             (state == HBAT_HOLD && strobe_on));
            if (state == HBAT_STALL && !req.write)
                o_data <= regs[req.addr[`HBAT_IDX_W-1:0]];
            o_data_oe_n <= !(state != HBAT_IDLE && !req.write && strobe_on && !sync2[1]);
        end
    end

    //------------------------------------------------------------
    // panel outputs
    //------------------------------------------------------------
    // halted under reset and during power save; no drive to a dark panel
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_panel_pixel_out <= '0;
            o_panel_line_pulse <= 1'b0;
            o_panel_frame_polarity <= 1'b0;
            line_cnt <= '0;
        end
        else if (!o_power_save && i_pixel_run)
        begin
            o_panel_pixel_out <= i_pixel;
            line_cnt <= line_cnt + 1'b1;
            o_panel_line_pulse <= (line_cnt == `HBAT_LINE_LAST);
            if (line_cnt == `HBAT_LINE_LAST)
                o_panel_frame_polarity <= !o_panel_frame_polarity;
        end
        else
            o_panel_line_pulse <= 1'b0;
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    a_wait_low_fast: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == HBAT_IDLE && strobe_fell) |=> !o_wait_n && !o_wait_oe_n)
        else $error("wait not driven low after strobe");
    a_wait_bounded: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $fell(o_wait_n) |-> ##[1:4] o_wait_n)
        else $error("wait held low too long");
    a_wait_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == HBAT_HOLD && !strobe_on) |=> o_wait_oe_n)
        else $error("wait not released after strobe");
    a_reset_halt: assert property (@(posedge i_ref_clk)
        i_rst |-> o_panel_pixel_out == '0 && !o_panel_line_pulse && !o_panel_frame_polarity)
        else $error("panel outputs not halted in reset");
    a_psave_exit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (take_write && DIRECT_MODE && req.addr[7:0] == `HBAT_PSAVE_INDEX
         && req.data[`HBAT_PSAVE_BIT]) |=> !o_power_save)
        else $error("power save not left");
    a_sysset_exit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (take_write && !DIRECT_MODE && req.addr[0] && req.data == `HBAT_SYSSET_CMD)
        |=> !o_power_save)
        else $error("power save not left on init command");
    a_psave_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_power_save) |-> 1'b0)
        else $error("power save re-entered without reset");
    a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == HBAT_IDLE && !strobe_fell) |=> o_wait_oe_n)
        else $error("wait driven without strobe");
    a_rdata_timing: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == HBAT_DONE && !req.write) |-> o_data == regs[req.addr[`HBAT_IDX_W-1:0]])
        else $error("read data not ready when wait rises");
    c_read: cover property (@(posedge i_ref_clk) state == HBAT_DONE && !req.write);
    c_write: cover property (@(posedge i_ref_clk) take_write);
    c_wake: cover property (@(posedge i_ref_clk) $fell(o_power_save));
endmodule // hbat_host_port
`default_nettype wire

// ### hbat_host_port_bench.sv
// bench for the host port: reset, stall, read back, power save exit
// assumes wait pin pulled up and bus shared with the host model
`timescale 1ns/10ps
`default_nettype none
`include "hbat_consts.svh"
module hbat_host_port_bench;
    import hbat_pkg::*;
    logic clk, rst, run, cs_n, rd_n, wr_n, wait_n, wait_oe_n, data_oe_n, ps, line, frame;
    logic ps_ind;
    logic [3:0] pix, pout;
    logic [15:0] addr;
    logic [7:0] hdata, ddata, q;
    int err_count, comparisons, lows;
    // pull-up on wait; bus shows the device only while it drives
    wire logic wait_w = wait_oe_n ? 1'b1 : wait_n;
    wire logic [7:0] bus = data_oe_n ? hdata : ddata;
    hbat_host_port hbat_host_port_inst (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(hdata), .i_pixel_run(run),
        .i_pixel(pix), .o_data(ddata), .o_data_oe_n(data_oe_n), .o_wait_n(wait_n),
        .o_wait_oe_n(wait_oe_n), .o_power_save(ps), .o_panel_pixel_out(pout),
        .o_panel_line_pulse(line), .o_panel_frame_polarity(frame));
    hbat_host_model hbat_host_model_inst (.i_ref_clk(clk), .i_wait(wait_w), .i_bus(bus),
        .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(hdata));
    // indirect-mode copy on the same host pins; only its power save is watched
    hbat_host_port #(.DIRECT_MODE(1'b0)) hbat_host_port_indirect_inst (.i_ref_clk(clk),
        .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr),
        .i_data(hdata), .i_pixel_run(run), .i_pixel(pix), .o_data(), .o_data_oe_n(),
        .o_wait_n(), .o_wait_oe_n(), .o_power_save(ps_ind), .o_panel_pixel_out(),
        .o_panel_line_pulse(), .o_panel_frame_polarity());
    // ------------------------------
    // helpers
    // ------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("Error: %s expected %h got %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    // panel kept still and wait pin released while reset holds
    task automatic t_in_reset();
        chk("panel", 8'h00, {2'b00, pout, line, frame});
        chk("wait oe", 8'h01, {7'h00, wait_oe_n});
        chk("psave", 8'h01, {7'h00, ps});
    endtask
    // write then read back; stall length bounded each time
    task automatic t_write_read();
        hbat_host_model_inst.acc(1'b1, 16'h0003, 8'hA5, q, lows);
        chk("stall write", 8'h01, {7'h00, lows >= 1 && lows <= `HBAT_WAIT_TS});
        hbat_host_model_inst.acc(1'b0, 16'h0003, 8'h00, q, lows);
        chk("stall read", 8'h01, {7'h00, lows >= 1 && lows <= `HBAT_WAIT_TS});
        chk("read data", 8'hA5, q);
        chk("wait released", 8'h01, {7'h00, wait_oe_n});
    endtask
    // wake index with bit 0 clear must not wake, with bit 0 set must
    task automatic t_wake();
        hbat_host_model_inst.acc(1'b1, 16'h0008, 8'hFE, q, lows);
        chk("psave kept", 8'h01, {7'h00, ps});
        hbat_host_model_inst.acc(1'b1, 16'h0008, 8'h01, q, lows);
        chk("psave left", 8'h00, {7'h00, ps});
        // oscillator settling stand-in before any further access
        repeat (4) @(posedge clk);
        chk("pixel run", 8'h0A, {4'h0, pout});
    endtask
    // indirect copy: only the init command at an odd index wakes it
    task automatic t_wake_indirect();
        chk("ind psave kept", 8'h01, {7'h00, ps_ind});
        hbat_host_model_inst.acc(1'b1, 16'h0001, `HBAT_SYSSET_CMD, q, lows);
        chk("ind psave left", 8'h00, {7'h00, ps_ind});
    endtask
    // reset in mid-run: panel halts, an access during it is ignored
    task automatic t_reset_midrun();
        rst <= 1'b1;
        @(posedge clk);
        chk("panel halted", 8'h00, {2'b00, pout, line, frame});
        hbat_host_model_inst.acc(1'b1, 16'h0008, 8'h01, q, lows);
        chk("reset stall", 8'h00, lows[7:0]);
        chk("reset wait oe", 8'h01, {7'h00, wait_oe_n});
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("psave after reset", 8'h01, {7'h00, ps});
        hbat_host_model_inst.acc(1'b1, 16'h0008, 8'h01, q, lows);
        chk("psave left again", 8'h00, {7'h00, ps});
    endtask
    // clock: 50 MHz
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog well beyond the hundred-odd cycles the run needs
    initial
    begin
        #50000;
        err_count++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        run = 1'b1;
        pix = 4'hA;
        repeat (6) @(posedge clk);
        t_in_reset();
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_write_read();
        t_wake();
        t_wake_indirect();
        t_reset_midrun();
        tally_and_finish();
    end
endmodule // hbat_host_port_bench
`default_nettype wire

// ### hbat_pkg.sv
// types for the host bus access block
// assumes the constants header sits in the same folder
`include "hbat_consts.svh"
package hbat_pkg;
    // one host access as seen after synchronising
    typedef struct packed {
        logic [`HBAT_ADDR_W-1:0] addr;
        logic [`HBAT_DATA_W-1:0] data;
        logic write;
    } hbat_req_s;
    typedef enum logic [2:0] {
        HBAT_IDLE = 3'b000,
        HBAT_STALL = 3'b001,
        HBAT_DONE = 3'b010,
        HBAT_HOLD = 3'b011
    } hbat_state_e;
endpackage
